// File: mca_pkg.sv
// Constants for the maintenance counter and alarm block.
// Assumes a 25 MHz system clock and a plain strobe register port.
package mca_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned HOLD_TIME_S     = 5;
  localparam int unsigned HOLD_CYCLES     = HOLD_TIME_S * CLK_HZ;
  localparam int unsigned TICK_TIME_S     = 36_000;
  // Ten hours of system clock does not fit in 32 bits
  localparam longint unsigned TICK_CYCLES = 64'(TICK_TIME_S) * 64'(CLK_HZ);
  localparam logic [7:0] ADDR_RUN_TIME    = 8'h00;
  localparam logic [7:0] ADDR_STARTS      = 8'h04;
  localparam logic [7:0] ADDR_INTERVAL    = 8'h08;
  localparam logic [7:0] ADDR_START_LIMIT = 8'h0C;
  localparam logic [7:0] ADDR_MOCK_ALARM  = 8'h10;
  localparam logic [7:0] ADDR_HIST_CLEAR  = 8'h14;
  localparam logic [7:0] ADDR_ASSIGN      = 8'h18;
  localparam logic [7:0] ADDR_STATUS      = 8'h1C;
  localparam logic [7:0] ADDR_HISTORY     = 8'h20;
  localparam logic [7:0] ADDR_RUN_M23     = 8'h24;
  localparam logic [7:0] ADDR_RUN_M4      = 8'h28;
  localparam logic [7:0] CODE_MAINS_M1    = 8'h48;
  localparam logic [7:0] CODE_MAINS_M4    = 8'h4B;
  localparam logic [7:0] CODE_MNT_OUT     = 8'h54;
  localparam logic [7:0] CODE_ALM_OUT     = 8'h63;
  localparam logic [7:0] MOCK_CODE        = 8'hEE;
  localparam logic [15:0] INTERVAL_MAX    = 16'h270F;
  localparam int unsigned HIST_DEPTH      = 4;
  localparam int unsigned ASSIGN_DI_LSB   = 0;
  localparam int unsigned ASSIGN_DO_LSB   = 8;
  localparam int unsigned ASSIGN_AO_LSB   = 16;
endpackage : mca_pkg

// File: mca_divider.sv
// Divider giving a one-cycle enable pulse every DIVIDE cycles while run_i is high; count restarts while run_i is low.
// Assumes a single clock domain.
module mca_divider #(
  parameter longint unsigned DIVIDE = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      tick_o
);
  // Wide enough for a ten-hour period at the system clock
  logic [39:0] count;
  wire         at_end = (count == 40'(DIVIDE - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count  <= 40'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= run_i & at_end;
      if (!run_i || at_end) begin
        count <= 40'h0;
      end else begin
        count <= count + 40'h1;
      end
    end
  end
endmodule : mca_divider

// File: mca_counter_alarm.sv
// Maintenance run-time / startup counters, maintenance due output, mock alarm.
// Assumes motor and pin inputs are asynchronous; registers via a strobe port.
// What this block does
// - Run-time counter may be preset; writing zero clears it.
// - Counts motor 1 run time while assigned mains contactor input is closed.
// - Motors 2 to 4 counted from mains inputs assigned codes 73 to 75.
// - Counters held binary internally; keypad does decimal conversion.
// - Interval in ten-hour units, zero disables, valid 1 to 9999.
// - Run time reaching interval raises maintenance due.
// - Startup limit 16 bits, zero disables, 0001 to FFFF active.
// - Startup count reaching limit raises maintenance due.
// - Maintenance due reaches a terminal only when assigned code 84.
// - New interval or limit written clears due and restarts counting.
// - Threshold comparison is made for motor 1 only.
// - Writing 1 to mock alarm shows fault and drives assigned alarm output.
// - Mock alarm setting returns to 0 by itself.
// - Mock alarm is recorded in alarm history like a real alarm.
// - History clear erases alarm data, then setting returns to 0.
// - Key pair held at least 5 seconds raises a mock alarm.
// - Counter value 0000 is the reset point for maintenance counting.
//
// The address map and strobed register access were chosen for this implementation.
module mca_counter_alarm
  import mca_pkg::*;
#(
  parameter int unsigned HOLD_COUNT = HOLD_CYCLES,
  parameter longint unsigned TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  // Motor and terminal inputs
  input  wire logic        MOTOR_RUN_I,
  input  wire logic [3:0]  DIG_IN_I,
  input  wire logic        KEY_PAIR_I,
  input  wire logic        REAL_ALARM_I,
  input  wire logic [7:0]  REAL_ALARM_CODE_I,
  // Outputs
  output logic             DIG_OUT_MNT_O,
  output logic             ALARM_OUT_O,
  output logic             MOCK_FAULT_O
);
  logic [1:0]  run_sync;
  logic [1:0]  key_sync;
  logic [1:0]  alm_sync;
  logic [3:0]  di_s1;
  logic [3:0]  di_s2;
  logic [7:0]  code_s1;
  logic [7:0]  code_s2;
  logic        run_prev;
  logic        alm_prev;
  logic [15:0] motor1_run_time_counter;
  logic [15:0] run_time_m [2:4];
  logic [15:0] motor1_startup_counter;
  logic [15:0] maintenance_interval_setting;
  logic [15:0] preset_startup_limit;
  logic [23:0] assign_cfg;
  logic        maintenance_due;
  logic        mock_latched;
  logic [31:0] hold_cnt;
  logic        key_done;
  logic [7:0]  history [0:HIST_DEPTH-1];
  logic [31:0] rdata_next;
  logic [3:0]  m_tick;

  // Mains-drive status per motor: assigned input terminal closed
  function automatic logic mains_on(input logic [7:0] code, input logic [3:0] di,
                                    input logic [7:0] sel);
    return (sel == code) && (di != 4'h0);
  endfunction : mains_on

  wire [7:0] di_code   = assign_cfg[ASSIGN_DI_LSB +: 8];
  wire [7:0] do_code   = assign_cfg[ASSIGN_DO_LSB +: 8];
  wire [7:0] ao_code   = assign_cfg[ASSIGN_AO_LSB +: 8];
  wire       run_m1    = run_sync[1] | mains_on(CODE_MAINS_M1, di_s2, di_code);
  wire       wr_run    = WR_I && (ADDR_I == ADDR_RUN_TIME);
  wire       wr_starts = WR_I && (ADDR_I == ADDR_STARTS);
  wire       wr_intv   = WR_I && (ADDR_I == ADDR_INTERVAL);
  wire       wr_limit  = WR_I && (ADDR_I == ADDR_START_LIMIT);
  wire       wr_mock   = WR_I && (ADDR_I == ADDR_MOCK_ALARM) && (WDATA_I[0] == 1'b1);
  wire       wr_clear  = WR_I && (ADDR_I == ADDR_HIST_CLEAR) && (WDATA_I[0] == 1'b1);
  wire       wr_assign = WR_I && (ADDR_I == ADDR_ASSIGN);
  wire       start_evt = run_sync[1] & ~run_prev;
  wire       key_hit   = key_sync[1] && (hold_cnt == 32'(HOLD_COUNT - 1)) && !key_done;
  wire       mock_evt  = wr_mock | key_hit;
  wire       real_evt  = alm_sync[1] & ~alm_prev;
  wire       hit_time  = (maintenance_interval_setting != 16'h0) &&
                         (motor1_run_time_counter >= maintenance_interval_setting);
  wire       hit_start = (preset_startup_limit != 16'h0) &&
                         (motor1_startup_counter >= preset_startup_limit);
  wire [15:0] intv_wr  = (WDATA_I[15:0] > INTERVAL_MAX) ? INTERVAL_MAX : WDATA_I[15:0];

  // Input synchronisers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_sync <= 2'h0;
      key_sync <= 2'h0;
      alm_sync <= 2'h0;
      di_s1    <= 4'h0;
      di_s2    <= 4'h0;
      run_prev <= 1'b0;
      alm_prev <= 1'b0;
      code_s1  <= 8'h0;
      code_s2  <= 8'h0;
    end else begin
      run_sync <= {run_sync[0], MOTOR_RUN_I};
      key_sync <= {key_sync[0], KEY_PAIR_I};
      alm_sync <= {alm_sync[0], REAL_ALARM_I};
      di_s1    <= DIG_IN_I;
      di_s2    <= di_s1;
      run_prev <= run_sync[1];
      alm_prev <= alm_sync[1];
      code_s1  <= REAL_ALARM_CODE_I;
      code_s2  <= code_s1;
    end
  end

  // Ten-hour tick per motor
  genvar g;
  for (g = 1; g <= 4; g++) begin : g_tick
    wire run_g = (g == 1) ? run_m1 :
                 mains_on(8'(CODE_MAINS_M1 + 8'(g - 1)), di_s2, di_code);
    mca_divider #(.DIVIDE(TICK_COUNT)) u_div (
      .clk_i  (CLK_I),
      .rst_i  (RST_I),
      .run_i  (run_g),
      .tick_o (m_tick[g-1])
    );
  end

  // Counters, held in binary; keypad converts for display
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      motor1_run_time_counter <= 16'h0;
      motor1_startup_counter  <= 16'h0;
      run_time_m[2]           <= 16'h0;
      run_time_m[3]           <= 16'h0;
      run_time_m[4]           <= 16'h0;
    end else begin
      if (wr_run) begin
        motor1_run_time_counter <= WDATA_I[15:0];
      end else if (wr_intv) begin
        motor1_run_time_counter <= 16'h0;
      end else if (m_tick[0] && motor1_run_time_counter != 16'hFFFF) begin
        motor1_run_time_counter <= motor1_run_time_counter + 16'h1;
      end
      if (wr_starts) begin
        motor1_startup_counter <= WDATA_I[15:0];
      end else if (wr_limit) begin
        motor1_startup_counter <= 16'h0;
      end else if (start_evt && motor1_startup_counter != 16'hFFFF) begin
        motor1_startup_counter <= motor1_startup_counter + 16'h1;
      end
      for (int m = 2; m <= 4; m++) begin
        if (m_tick[m-1] && run_time_m[m] != 16'hFFFF) begin
          run_time_m[m] <= run_time_m[m] + 16'h1;
        end
      end
    end
  end

  // Settings and maintenance due flag
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      maintenance_interval_setting <= 16'h0;
      preset_startup_limit         <= 16'h0;
      assign_cfg                   <= 24'h0;
      maintenance_due              <= 1'b0;
    end else begin
      if (wr_intv) begin
        maintenance_interval_setting <= intv_wr;
      end
      if (wr_limit) begin
        preset_startup_limit <= WDATA_I[15:0];
      end
      if (wr_assign) begin
        assign_cfg <= WDATA_I[23:0];
      end
      if (wr_intv || wr_limit) begin
        maintenance_due <= 1'b0;
      end else if (hit_time || hit_start) begin
        maintenance_due <= 1'b1;
      end
    end
  end

  // Key pair hold timer and mock alarm
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hold_cnt     <= 32'h0;
      key_done     <= 1'b0;
      mock_latched <= 1'b0;
    end else begin
      if (!key_sync[1]) begin
        hold_cnt <= 32'h0;
        key_done <= 1'b0;
      end else if (key_hit) begin
        key_done <= 1'b1;
      end else if (!key_done) begin
        hold_cnt <= hold_cnt + 32'h1;
      end
      // Setting itself is never stored, so it always reads back as 0
      if (mock_evt) begin
        mock_latched <= 1'b1;
      end else if (WR_I && ADDR_I == ADDR_MOCK_ALARM) begin
        mock_latched <= 1'b0;
      end
    end
  end

  // Alarm history, newest at slot 0
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        history[i] <= 8'h0;
      end
    end else if (mock_evt || real_evt) begin
      history[0] <= mock_evt ? MOCK_CODE : code_s2;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        history[i] <= history[i-1];
      end
    end else if (wr_clear) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        history[i] <= 8'h0;
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_next = 32'h0;
    case (ADDR_I)
      ADDR_RUN_TIME:    rdata_next = {16'h0, motor1_run_time_counter};
      ADDR_STARTS:      rdata_next = {16'h0, motor1_startup_counter};
      ADDR_INTERVAL:    rdata_next = {16'h0, maintenance_interval_setting};
      ADDR_START_LIMIT: rdata_next = {16'h0, preset_startup_limit};
      ADDR_ASSIGN:      rdata_next = {8'h0, assign_cfg};
      ADDR_STATUS:      rdata_next = {29'h0, mock_latched, ALARM_OUT_O, maintenance_due};
      ADDR_HISTORY:     rdata_next = {history[3], history[2], history[1], history[0]};
      ADDR_RUN_M23:     rdata_next = {run_time_m[3], run_time_m[2]};
      ADDR_RUN_M4:      rdata_next = {16'h0, run_time_m[4]};
      default:          rdata_next = 32'h0;
    endcase
  end

  // Outputs from flip-flops
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O       <= 32'h0;
      DIG_OUT_MNT_O <= 1'b0;
      ALARM_OUT_O   <= 1'b0;
      MOCK_FAULT_O  <= 1'b0;
    end else begin
      RDATA_O       <= RD_I ? rdata_next : 32'h0;
      DIG_OUT_MNT_O <= maintenance_due && (do_code == CODE_MNT_OUT);
      MOCK_FAULT_O  <= mock_latched | mock_evt;
      ALARM_OUT_O   <= (mock_latched | mock_evt | alm_sync[1]) &&
                       (ao_code == CODE_ALM_OUT);
    end
  end

  mnt_clear_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_intv || wr_limit) |=> !maintenance_due)
    else $error("due not cleared by new setting");
  mnt_route_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    DIG_OUT_MNT_O |-> $past(do_code) == CODE_MNT_OUT)
    else $error("due output without assignment");
  run_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_run && WDATA_I[15:0] == 16'h0) |=> motor1_run_time_counter == 16'h0)
    else $error("run time not cleared");
  start_count_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (start_evt && !wr_starts && !wr_limit && motor1_startup_counter != 16'hFFFF) |=>
      motor1_startup_counter == $past(motor1_startup_counter) + 16'h1)
    else $error("startup not counted");
  time_due_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (hit_time && !wr_intv && !wr_limit) |=> maintenance_due)
    else $error("interval hit ignored");
  start_due_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (hit_start && !wr_intv && !wr_limit) |=> maintenance_due)
    else $error("startup limit hit ignored");
  mock_fault_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_mock |=> MOCK_FAULT_O && history[0] == MOCK_CODE)
    else $error("mock alarm not raised");
  hist_clear_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_clear && !mock_evt && !real_evt) |=> history[0] == 8'h0)
    else $error("history not cleared");
  intv_range_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    maintenance_interval_setting <= INTERVAL_MAX)
    else $error("interval out of range");
  rdata_idle_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data outside read cycle");
  run_tick_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (m_tick[0] && !wr_run && !wr_intv && motor1_run_time_counter != 16'hFFFF) |=>
      motor1_run_time_counter == $past(motor1_run_time_counter) + 16'h1)
    else $error("run time tick not counted");
  hist_real_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (real_evt && !mock_evt) |=> history[0] == $past(code_s2))
    else $error("real alarm not recorded");
  alarm_route_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    ALARM_OUT_O |-> $past(ao_code) == CODE_ALM_OUT)
    else $error("alarm output without assignment");
endmodule : mca_counter_alarm

// File: mca_panel_model.sv
// Model of the keypad and the external sequence logic on the terminals.
// Assumes the bench asks for actions; each pin follows its request one clock later.
module mca_panel_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Requests from the bench
  input  wire logic       run_req_i,
  input  wire logic [3:0] mains_req_i,
  input  wire logic       keys_req_i,
  // Terminal pins
  output logic            motor_run_o,
  output logic      [3:0] dig_in_o,
  output logic            key_pair_o
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      motor_run_o <= 1'b0;
      dig_in_o    <= 4'h0;
      key_pair_o  <= 1'b0;
    end else begin
      motor_run_o <= run_req_i;
      dig_in_o    <= mains_req_i;
      key_pair_o  <= keys_req_i;
    end
  end
endmodule : mca_panel_model

// File: maintenance_counter_alarm_tb_top.sv
// Self-checking bench for the maintenance counter and alarm block.
// Assumes short hold and tick counts so each scenario runs in a few cycles.
module maintenance_counter_alarm_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mca_pkg::*;
  logic        clk, rst, wr, rd, run_req, keys_req, real_alm;
  logic [7:0]  addr, real_code;
  logic [31:0] wdata, rdata, v, b;
  logic [3:0]  mains_req, dig_in;
  logic        motor_run, key_pair, maintenance_due_output, any_alarm_output, mock;
  logic [2:0]  outs;
  int          err_count, check_count;
  assign outs = {mock, any_alarm_output, maintenance_due_output};

  mca_panel_model panel (.clk_i(clk), .rst_i(rst), .run_req_i(run_req),
    .mains_req_i(mains_req), .keys_req_i(keys_req), .motor_run_o(motor_run),
    .dig_in_o(dig_in), .key_pair_o(key_pair));
  mca_counter_alarm #(.HOLD_COUNT(20), .TICK_COUNT(4)) uut (.CLK_I(clk), .RST_I(rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .MOTOR_RUN_I(motor_run), .DIG_IN_I(dig_in), .KEY_PAIR_I(key_pair),
    .REAL_ALARM_I(real_alm), .REAL_ALARM_CODE_I(real_code), .DIG_OUT_MNT_O(maintenance_due_output),
    .ALARM_OUT_O(any_alarm_output), .MOCK_FAULT_O(mock));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic wait_out(input string what, input int idx, input logic val);
    int n;
    n = 0;
    while (outs[idx] !== val && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(what, {31'h0, outs[idx]}, {31'h0, val});
    if (outs[idx] !== val) tally_and_finish();
  endtask : wait_out

  task automatic t_interval();
    wr_reg(ADDR_INTERVAL, 32'h0000FFFF);
    rd_reg(ADDR_INTERVAL, v);
    check("interval clip", v, {16'h0, INTERVAL_MAX});
    wr_reg(ADDR_ASSIGN, {8'h00, CODE_ALM_OUT, CODE_MNT_OUT, CODE_MAINS_M1});
    wr_reg(ADDR_INTERVAL, 32'h5);
    wr_reg(ADDR_RUN_TIME, 32'h4);
    rd_reg(ADDR_RUN_TIME, v);
    check("run preset", v, 32'h4);
    check("due early", {31'h0, maintenance_due_output}, 32'h0);
    wr_reg(ADDR_RUN_TIME, 32'h5);
    wait_out("due at interval", 0, 1'b1);
    wr_reg(ADDR_RUN_TIME, 32'h0);
    rd_reg(ADDR_RUN_TIME, v);
    check("run clear", v, 32'h0);
    wr_reg(ADDR_INTERVAL, 32'h2);
    wait_out("due cleared", 0, 1'b0);
    run_req <= 1'b1;
    wait_out("due by running", 0, 1'b1);
    run_req <= 1'b0;
    rd_reg(ADDR_RUN_TIME, v);
    check("run reached", {31'h0, v >= 32'h2}, 32'h1);
  endtask : t_interval

  task automatic t_terminal();
    wr_reg(ADDR_ASSIGN, {8'h00, CODE_ALM_OUT, 8'h00, CODE_MAINS_M1});
    rd_reg(ADDR_STATUS, v);
    check("due status", {31'h0, v[0]}, 32'h1);
    check("unassigned pin", {31'h0, maintenance_due_output}, 32'h0);
    wr_reg(ADDR_ASSIGN, {8'h00, CODE_ALM_OUT, CODE_MNT_OUT, CODE_MAINS_M1});
    wait_out("assigned pin", 0, 1'b1);
  endtask : t_terminal

  task automatic t_mains();
    int sh;
    logic [7:0] a;
    wr_reg(ADDR_INTERVAL, 32'h0);
    mains_req <= 4'h1;
    repeat (20) @(posedge clk);
    mains_req <= 4'h0;
    repeat (4) @(posedge clk);
    rd_reg(ADDR_RUN_TIME, v);
    check("mains m1", {31'h0, v != 32'h0}, 32'h1);
    check("zero interval", {31'h0, maintenance_due_output}, 32'h0);
    wr_reg(ADDR_INTERVAL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      a  = (i == 2) ? ADDR_RUN_M4 : ADDR_RUN_M23;
      sh = (i == 1) ? 16 : 0;
      wr_reg(ADDR_ASSIGN, {8'h00, CODE_ALM_OUT, CODE_MNT_OUT, 8'(CODE_MAINS_M1 + 8'(i + 1))});
      rd_reg(a, b);
      mains_req <= 4'h4;
      repeat (20) @(posedge clk);
      mains_req <= 4'h0;
      repeat (4) @(posedge clk);
      rd_reg(a, v);
      check("mains other", {31'h0, v[sh+:16] > b[sh+:16]}, 32'h1);
    end
    rd_reg(ADDR_RUN_TIME, v);
    check("m1 untouched", v, 32'h0);
    rd_reg(ADDR_STATUS, v);
    check("no due from others", {31'h0, v[0]}, 32'h0);
    wr_reg(ADDR_INTERVAL, 32'h0);
  endtask : t_mains

  task automatic t_starts();
    wr_reg(ADDR_START_LIMIT, 32'h3);
    for (int i = 0; i < 3; i++) begin
      run_req <= 1'b1;
      repeat (6) @(posedge clk);
      run_req <= 1'b0;
      repeat (6) @(posedge clk);
    end
    rd_reg(ADDR_STARTS, v);
    check("starts", v, 32'h3);
    wait_out("due by starts", 0, 1'b1);
    wr_reg(ADDR_STARTS, 32'h0);
    rd_reg(ADDR_STARTS, v);
    check("starts clear", v, 32'h0);
    wr_reg(ADDR_START_LIMIT, 32'hFFFF);
    rd_reg(ADDR_START_LIMIT, v);
    check("limit max", v, 32'hFFFF);
    wait_out("due after limit", 0, 1'b0);
  endtask : t_starts

  task automatic t_mock();
    real_code <= 8'h5A;
    real_alm  <= 1'b1;
    wait_out("real alarm pin", 1, 1'b1);
    real_alm  <= 1'b0;
    wait_out("real alarm off", 1, 1'b0);
    wr_reg(ADDR_MOCK_ALARM, 32'h1);
    wait_out("mock fault", 2, 1'b1);
    wait_out("alarm pin", 1, 1'b1);
    rd_reg(ADDR_MOCK_ALARM, v);
    check("mock self clear", v, 32'h0);
    rd_reg(ADDR_HISTORY, v);
    check("history", {16'h0, v[15:0]}, {16'h0, 8'h5A, MOCK_CODE});
    wr_reg(ADDR_HIST_CLEAR, 32'h1);
    rd_reg(ADDR_HISTORY, v);
    check("history cleared", v, 32'h0);
    rd_reg(ADDR_HIST_CLEAR, v);
    check("clear self clear", v, 32'h0);
    wr_reg(ADDR_MOCK_ALARM, 32'h0);
    wait_out("mock reset", 2, 1'b0);
  endtask : t_mock

  task automatic t_keys();
    keys_req <= 1'b1;
    repeat (10) @(posedge clk);
    keys_req <= 1'b0;
    repeat (4) @(posedge clk);
    check("short hold", {31'h0, mock}, 32'h0);
    keys_req <= 1'b1;
    wait_out("long hold", 2, 1'b1);
    keys_req <= 1'b0;
  endtask : t_keys

  // Reset in mid-run must clear every output, the status bits and the motor 1 run-time counter
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("outputs after reset", {29'h0, outs}, 32'h0);
    rd_reg(ADDR_STATUS, v);
    check("status after reset", v, 32'h0);
    rd_reg(ADDR_RUN_TIME, v);
    check("run after reset", v, 32'h0);
  endtask : t_reset

  initial begin
    rst = 1'b1;
    {wr, rd, run_req, keys_req, real_alm, real_code, addr, wdata, mains_req} = '0;
    err_count = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ADDR_RUN_TIME, v);
    check("run reset", v, 32'h0);
    rd_reg(8'h3C, v);
    check("unmapped", v, 32'h0);
    t_interval();
    t_terminal();
    t_mains();
    t_starts();
    t_mock();
    t_keys();
    t_reset();
    tally_and_finish();
  end
endmodule : maintenance_counter_alarm_tb_top
